// file: tpc_pkg.sv
// package of constants for the trace port capture front end
// assumes a single 20 MHz system clock, no software registers
package tpc_pkg;

    localparam int unsigned CLK_PERIOD_NS   = 50;
    localparam int unsigned TRACE_LINES     = 20;
    localparam int unsigned WORD_W          = 20;
    localparam int unsigned FULL_MIN_MHZ    = 1;
    localparam int unsigned FULL_MAX_MHZ    = 200;
    localparam int unsigned HALF_MAX_MHZ    = 100;
    localparam int unsigned TPERIOD_MAX_NS  = 1000;
    localparam int unsigned TPERIOD_MIN_NS  = 5;
    // longest trace clock period in system clocks, rounded down
    localparam int unsigned TPERIOD_MAX_CYC =
        (TPERIOD_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (TPERIOD_MAX_NS / CLK_PERIOD_NS);

    // port width selection
    localparam logic [1:0] WIDTH_4  = 2'h0;
    localparam logic [1:0] WIDTH_8  = 2'h1;
    localparam logic [1:0] WIDTH_16 = 2'h2;

    // architecture version selection
    localparam logic [1:0] ARCH_V1 = 2'h0;
    localparam logic [1:0] ARCH_V2 = 2'h1;
    localparam logic [1:0] ARCH_V3 = 2'h2;

    // packed word layout
    localparam int unsigned F_DATA_LSB  = 0;
    localparam int unsigned F_DATA_W    = 16;
    localparam int unsigned F_STAT_LSB  = 16;
    localparam int unsigned F_STAT_W    = 4;
    localparam int unsigned F_SYNC_BIT  = 19;
    localparam int unsigned F_CTL_BIT   = 16;

    // line numbers (1 based) of the connector
    localparam int unsigned LN_STAT0 = 1;
    localparam int unsigned LN_STAT3 = 4;
    localparam int unsigned LN_PKT0  = 5;
    localparam int unsigned LN_V3D1  = 6;
    localparam int unsigned LN_V3CTL = 2;
    localparam int unsigned LN_V3HI  = 3;
    localparam int unsigned LN_V3LO0 = 4;
    localparam int unsigned LN_V3LO1 = 5;

    // active data lanes of the narrow port widths
    localparam int unsigned LANES_4     = 4;
    localparam int unsigned LANES_8     = 8;
    // version 1 carries three status bits, sync takes the fourth place
    localparam int unsigned F_STAT_V1_W = 3;

    typedef enum logic [1:0] {
        TPC_IDLE = 2'b00,
        TPC_RUN  = 2'b01,
        TPC_LOST = 2'b10
    } tpc_state_t;

endpackage : tpc_pkg

// file: tpc_word_reg.sv
// one-word holding register between capture and trace storage
// assumes the storage side drains with a ready on the same clock
`timescale 1ns/1ps
module tpc_word_reg
    import tpc_pkg::*;
#(
    parameter int unsigned W = WORD_W
) (
    input  wire logic         clock,
    input  wire logic         reset,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_word,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_word,
    input  wire logic         out_ready
);
    always_ff @(posedge clock) begin
        if (reset) begin
            out_valid <= 1'b0;
        end else if (in_valid && in_ready) begin
            out_valid <= 1'b1;
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            out_word <= '0;
        end else if (in_valid && in_ready) begin
            out_word <= in_word;
        end
    end

    assign in_ready = !out_valid || out_ready;
endmodule : tpc_word_reg

// file: tpc_capture.sv
// trace port capture front end: samples connector trace lines on the
// trace clock edges, maps them per architecture, packs and forwards
// assumes trace lines and trace clock come from pins (asynchronous)
`timescale 1ns/1ps

// Contract
// - sample status, sync, packet lines on rising, or both edges
// - support 4, 8 and 16 bit data widths, mask inactive lines
// - versions 1,2: lines 1-3 status, 5-20 packet, line 4 sync/status3
// - version 3: line 1 data0, line 2 control, 6-20 data 1-15
// - full rate accepts trace clock 1 to 200 MHz; sampled here by the 20 MHz system clock, it is followed only below 10 MHz
// - half rate: new data each edge, clock at most 100 MHz; sampled here by the 20 MHz system clock, edges are followed only below 10 MHz
module tpc_capture
    import tpc_pkg::*;
#(
    parameter int unsigned LINES = TRACE_LINES
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             trace_sample_clock,
    input  wire logic [LINES-1:0] trace_lines,
    input  wire logic             both_edges,
    input  wire logic [1:0]       port_width,
    input  wire logic [1:0]       arch_version,
    input  wire logic             capture_enable,
    output logic                  word_valid,
    output logic [WORD_W-1:0]     word_data,
    input  wire logic             word_ready,
    output logic                  overrun_reg,
    output logic                  clock_stalled_reg,
    output logic                  v3_fixed_error_reg
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic             clk_meta_reg;
    logic             clk_sync_reg;
    logic             clk_prev_reg;
    logic [LINES-1:0] lines_meta_reg;
    logic [LINES-1:0] lines_sync_reg;

    always_ff @(posedge clock) begin
        if (reset) begin
            clk_meta_reg   <= 1'b0;
            clk_sync_reg   <= 1'b0;
            clk_prev_reg   <= 1'b0;
            lines_meta_reg <= '0;
            lines_sync_reg <= '0;
        end else begin
            clk_meta_reg   <= trace_sample_clock;
            clk_sync_reg   <= clk_meta_reg;
            clk_prev_reg   <= clk_sync_reg;
            lines_meta_reg <= trace_lines;
            lines_sync_reg <= lines_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // edge selection
    // ------------------------------------------------------------
    logic rise;
    logic fall;
    logic take;
    assign rise = clk_sync_reg && !clk_prev_reg;
    assign fall = !clk_sync_reg && clk_prev_reg;
    // rising only, or each edge for half-rate clocking
    assign take = rise || (both_edges && fall);

    // ------------------------------------------------------------
    // width mask, one bit per data lane
    // ------------------------------------------------------------
    logic [F_DATA_W-1:0] width_mask;
    genvar gi;
    generate
        for (gi = 0; gi < F_DATA_W; gi++) begin : g_mask
            always_comb begin
                case (port_width)
                    WIDTH_4:  width_mask[gi] = (gi < LANES_4);
                    WIDTH_8:  width_mask[gi] = (gi < LANES_8);
                    default:  width_mask[gi] = 1'b1;
                endcase
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // line mapping per architecture version
    // ------------------------------------------------------------
    logic [WORD_W-1:0]   packed_word;
    logic [F_DATA_W-1:0] pkt_raw;
    logic [F_DATA_W-1:0] v3_raw;
    logic                fixed_bad;

    // packet lanes: lines 5..20 (index 4..19)
    assign pkt_raw = lines_sync_reg[LN_PKT0-1 +: F_DATA_W];
    // version 3 data: bit0 on line 1, bits 1..15 on lines 6..20
    assign v3_raw  = {lines_sync_reg[LN_V3D1-1 +: F_DATA_W-1],
                      lines_sync_reg[LN_STAT0-1]};
    // lines 3,4,5 must read 1,0,0 in version 3
    assign fixed_bad = !lines_sync_reg[LN_V3HI-1]
                       || lines_sync_reg[LN_V3LO0-1]
                       || lines_sync_reg[LN_V3LO1-1];

    always_comb begin
        packed_word = '0;
        case (arch_version)
            ARCH_V1: begin
                packed_word[F_DATA_LSB +: F_DATA_W] =
                    pkt_raw & width_mask;
                packed_word[F_STAT_LSB +: F_STAT_V1_W] =
                    lines_sync_reg[LN_STAT0-1 +: F_STAT_V1_W];
                packed_word[F_SYNC_BIT] =
                    lines_sync_reg[LN_STAT3-1];
            end
            ARCH_V2: begin
                packed_word[F_DATA_LSB +: F_DATA_W] =
                    pkt_raw & width_mask;
                packed_word[F_STAT_LSB +: F_STAT_W] =
                    lines_sync_reg[LN_STAT0-1 +: F_STAT_W];
            end
            ARCH_V3: begin
                packed_word[F_DATA_LSB +: F_DATA_W] =
                    v3_raw & width_mask;
                packed_word[F_CTL_BIT] =
                    lines_sync_reg[LN_V3CTL-1];
            end
            default: begin
                packed_word = '0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // trace clock watchdog: slower than 1 MHz counts as stalled
    // ------------------------------------------------------------
    localparam int unsigned WD_W = $clog2(TPERIOD_MAX_CYC + 1) + 1;
    localparam logic [WD_W-1:0] WD_LIMIT = WD_W'(TPERIOD_MAX_CYC);
    logic [WD_W-1:0] wd_reg;
    tpc_state_t      state_reg;

    always_ff @(posedge clock) begin
        if (reset || rise) begin
            wd_reg <= '0;
        end else if (wd_reg != WD_LIMIT) begin
            wd_reg <= wd_reg + WD_W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= TPC_IDLE;
        end else begin
            case (state_reg)
                TPC_IDLE: if (capture_enable && rise) state_reg <= TPC_RUN;
                TPC_RUN: begin
                    if (!capture_enable) begin
                        state_reg <= TPC_IDLE;
                    end else if (wd_reg == WD_LIMIT) begin
                        state_reg <= TPC_LOST;
                    end
                end
                TPC_LOST: begin
                    if (!capture_enable) begin
                        state_reg <= TPC_IDLE;
                    end else if (rise) begin
                        state_reg <= TPC_RUN;
                    end
                end
                default: state_reg <= TPC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            clock_stalled_reg <= 1'b0;
        end else begin
            clock_stalled_reg <= (state_reg == TPC_LOST);
        end
    end

    // ------------------------------------------------------------
    // forwarding into the holding register
    // ------------------------------------------------------------
    logic cap_valid;
    logic cap_ready;
    // the enabling rise itself is the first word kept
    assign cap_valid = take && (state_reg != TPC_IDLE
                                || (capture_enable && rise));

    tpc_word_reg #(.W(WORD_W)) u_hold (
        .clock     (clock),
        .reset     (reset),
        .in_valid  (cap_valid),
        .in_word   (packed_word),
        .in_ready  (cap_ready),
        .out_valid (word_valid),
        .out_word  (word_data),
        .out_ready (word_ready)
    );

    // a sample that cannot be stored is flagged, never silently lost
    always_ff @(posedge clock) begin
        if (reset) begin
            overrun_reg <= 1'b0;
        end else if (cap_valid && !cap_ready) begin
            overrun_reg <= 1'b1;
        end else if (!capture_enable) begin
            overrun_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            v3_fixed_error_reg <= 1'b0;
        end else if (cap_valid && arch_version == ARCH_V3 && fixed_bad) begin
            v3_fixed_error_reg <= 1'b1;
        end else if (!capture_enable) begin
            v3_fixed_error_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_word_on_edge: assert property (@(posedge clock) disable iff (reset)
        cap_valid && cap_ready |=> word_valid && word_data == $past(packed_word))
        else $error("captured word not presented");
    chk_rise_takes: assert property (@(posedge clock) disable iff (reset)
        rise && state_reg == TPC_RUN |-> cap_valid)
        else $error("rising edge not sampled");
    chk_fall_mode: assert property (@(posedge clock) disable iff (reset)
        fall && !both_edges |-> !cap_valid)
        else $error("falling edge sampled in rising mode");
    chk_fall_both: assert property (@(posedge clock) disable iff (reset)
        fall && both_edges && state_reg != TPC_IDLE |-> cap_valid)
        else $error("falling edge missed in half rate");
    chk_width_mask: assert property (@(posedge clock) disable iff (reset)
        port_width == WIDTH_4 |-> packed_word[F_DATA_W-1:LANES_4] == '0)
        else $error("inactive lanes not masked");
    chk_v2_status: assert property (@(posedge clock) disable iff (reset)
        arch_version == ARCH_V2 |->
        packed_word[F_STAT_LSB+F_STAT_W-1] == lines_sync_reg[LN_STAT3-1])
        else $error("status bit 3 mapping wrong");
    chk_v3_ctl: assert property (@(posedge clock) disable iff (reset)
        arch_version == ARCH_V3 |->
        packed_word[F_CTL_BIT] == lines_sync_reg[LN_V3CTL-1]
        && packed_word[F_DATA_LSB] == lines_sync_reg[LN_STAT0-1])
        else $error("version 3 mapping wrong");
    chk_hold_stall: assert property (@(posedge clock) disable iff (reset)
        word_valid && !word_ready |=> word_valid && $stable(word_data))
        else $error("word changed under stall");
    chk_stall_det: assert property (@(posedge clock) disable iff (reset)
        state_reg == TPC_RUN && capture_enable && wd_reg == WD_LIMIT
        |=> state_reg == TPC_LOST)
        else $error("slow clock not detected");
    chk_first_word: assert property (@(posedge clock) disable iff (reset)
        state_reg == TPC_IDLE && capture_enable && rise && cap_ready
        |=> word_valid)
        else $error("first edge after enable dropped");
endmodule : tpc_capture

// file: tpc_trace_src.sv
// target side model: trace clock and connector trace lines
// assumes the bench starts and stops it with run
`timescale 1ns/1ps
module tpc_trace_src
    import tpc_pkg::*;
(
    input  wire logic   run,
    input  wire logic   both_edges,
    input  wire logic   v3_mode,
    input  wire logic   v3_break,
    output logic        trace_sample_clock,
    output logic [19:0] trace_lines
);
    // ------
    // source
    // ------
    // trace clock toggles once per cycle of a 5 MHz processor clock
    localparam int CPU_PERIOD_NS = 200;
    localparam int SETUP_NS      = 25;
    logic [19:0] sent[$];
    logic [19:0] n;

    initial begin
        trace_sample_clock = 1'b0;
        trace_lines = 20'h00000;
        n = 20'h00001;
        forever begin
            wait (run);
            #13;
            // 400 ns period; stops only with the clock low
            while (run || trace_sample_clock) begin
                trace_lines = n * 20'h0B1D3 ^ 20'h5A3C7;
                if (v3_mode) begin
                    trace_lines[2] = ~v3_break;
                    trace_lines[4:3] = 2'h0;
                end
                n = n + 20'h00001;
                #(SETUP_NS);
                trace_sample_clock = ~trace_sample_clock;
                // new data before every edge for half rate
                if (both_edges || trace_sample_clock) begin
                    sent.push_back(trace_lines);
                end
                #(CPU_PERIOD_NS - SETUP_NS);
            end
        end
    end
endmodule : tpc_trace_src

// file: tpc_capture_tb_top.sv
// self-checking bench for the trace port capture front end
// assumes tpc_trace_src as the target side of the trace port
`timescale 1ns/1ps
module tpc_capture_tb_top
    import tpc_pkg::*;
;
    // ------
    // set-up
    // ------
    logic        clock;
    logic        reset;
    logic        both_edges;
    logic [1:0]  port_width;
    logic [1:0]  arch_version;
    logic        capture_enable;
    logic        word_ready;
    logic        run;
    logic        v3_break;
    wire         tsc;
    wire [19:0]  lines;
    wire         word_valid;
    wire [19:0]  word_data;
    wire         ovr;
    wire         stall;
    wire         v3err;
    wire         v3_mode = (arch_version == ARCH_V3);
    logic [19:0] got[$];
    int          fail_count;
    int          n_compared;

    tpc_capture tpc_capture_inst (.clock(clock), .reset(reset),
        .trace_sample_clock(tsc), .trace_lines(lines),
        .both_edges(both_edges), .port_width(port_width),
        .arch_version(arch_version), .capture_enable(capture_enable),
        .word_valid(word_valid), .word_data(word_data),
        .word_ready(word_ready), .overrun_reg(ovr),
        .clock_stalled_reg(stall), .v3_fixed_error_reg(v3err));
    tpc_trace_src tpc_trace_src_inst (.run(run), .both_edges(both_edges),
        .v3_mode(v3_mode), .v3_break(v3_break),
        .trace_sample_clock(tsc), .trace_lines(lines));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    always @(posedge clock) begin
        if (word_valid === 1'b1 && word_ready === 1'b1) begin
            got.push_back(word_data);
        end
    end

    // -------
    // helpers
    // -------
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    task automatic check_word(input logic [19:0] g, input logic [19:0] e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t word %h exp %h", $time, g, e);
        end
    endtask : check_word

    task automatic check_bit(input logic g, input logic e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t flag %b exp %b", $time, g, e);
        end
    endtask : check_bit

    task automatic ticks(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : ticks

    task automatic give_up(input int i, input int lim);
        if (i >= lim) begin
            fail_count++;
            $display("CHECK FAILED t=%0t wait ran out", $time);
            finish_test();
        end
    endtask : give_up

    function automatic logic [19:0] exp_word(input logic [19:0] l);
        logic [15:0] d;
        d = v3_mode ? {l[19:5], l[0]} : l[19:4];
        if (port_width == WIDTH_4) d = d & 16'h000F;
        if (port_width == WIDTH_8) d = d & 16'h00FF;
        if (arch_version > ARCH_V3) return 20'h00000;
        return v3_mode ? {3'h0, l[1], d} : {l[3], l[2:0], d};
    endfunction : exp_word

    // start a capture, send n edge words, leave enable high
    task automatic start(input logic [1:0] a, input logic [1:0] w,
                         input logic b, input int n);
        int i;
        capture_enable = 1'b0;
        arch_version = a;
        port_width = w;
        both_edges = b;
        ticks(2);
        got.delete();
        tpc_trace_src_inst.sent.delete();
        capture_enable = 1'b1;
        ticks(2);
        run = 1'b1;
        for (i = 0; i < 900 && tpc_trace_src_inst.sent.size() < n; i++)
            ticks(1);
        give_up(i, 900);
        run = 1'b0;
    endtask : start

    task automatic run_case(input logic [1:0] a, input logic [1:0] w,
                            input logic b, input int n);
        int i;
        start(a, w, b, n);
        for (i = 0; i < 200 && (tsc !== 1'b0 ||
             got.size() < tpc_trace_src_inst.sent.size()); i++) ticks(1);
        give_up(i, 200);
        check_bit(got.size() == tpc_trace_src_inst.sent.size(), 1'b1);
        foreach (tpc_trace_src_inst.sent[k]) begin
            check_word(got[k], exp_word(tpc_trace_src_inst.sent[k]));
        end
    endtask : run_case

    // ---------
    // scenarios
    // ---------
    task automatic sc_map;
        for (int a = 0; a < 4; a++)
            for (int w = 0; w < 4; w++)
                run_case(a[1:0], w[1:0], 1'b0, 4);
    endtask : sc_map

    task automatic sc_overrun;
        word_ready = 1'b0;
        start(ARCH_V2, WIDTH_16, 1'b0, 3);
        ticks(4);
        check_bit(ovr, 1'b1);
        check_bit(word_valid, 1'b1);
        check_word(word_data, exp_word(tpc_trace_src_inst.sent[0]));
        word_ready = 1'b1;
        capture_enable = 1'b0;
        ticks(4);
        check_bit(ovr, 1'b0);
    endtask : sc_overrun

    task automatic sc_stall;
        start(ARCH_V1, WIDTH_8, 1'b0, 2);
        check_bit(stall, 1'b0);
        ticks(30);
        check_bit(stall, 1'b1);
    endtask : sc_stall

    initial begin
        reset = 1'b1;
        both_edges = 1'b0;
        port_width = WIDTH_16;
        arch_version = ARCH_V1;
        capture_enable = 1'b0;
        word_ready = 1'b1;
        run = 1'b0;
        v3_break = 1'b0;
        fail_count = 0;
        n_compared = 0;
        ticks(8);
        reset = 1'b0;
        ticks(1);
        check_bit(word_valid, 1'b0);
        sc_map();
        run_case(ARCH_V2, WIDTH_16, 1'b1, 8);
        run_case(ARCH_V3, WIDTH_4, 1'b1, 6);
        sc_overrun();
        sc_stall();
        check_bit(v3err, 1'b0);
        v3_break = 1'b1;
        run_case(ARCH_V3, WIDTH_16, 1'b0, 2);
        check_bit(v3err, 1'b1);
        finish_test();
    end
endmodule : tpc_capture_tb_top
